/* fdc_host_model.sv */
`timescale 1ns/1ps
// host-side partner: configure command, terminal count and result-phase fetches
module fdc_host_model (
    input wire logic clk,
    input wire logic [7:0] resultByte,
    output logic configWrite,
    output logic configFifoEnable,
    output logic resultRead,
    output logic [1:0] resultSel,
    output logic transfer_count_end
);
    // idle values; released qualifiers show the inverse so stale data never helps
    initial begin
        configWrite = 1'b0;
        configFifoEnable = 1'b1;
        resultRead = 1'b0;
        resultSel = 2'h3;
        transfer_count_end = 1'b0;
    end

    // fifo setting only travels with the configure command
    task automatic configure(input logic en);
        @(posedge clk);
        configWrite <= 1'b1;
        configFifoEnable <= en;
        @(posedge clk);
        configWrite <= 1'b0;
        configFifoEnable <= ~en;
    endtask : configure

    // terminal count is a host-side level, changed just after an edge
    task automatic setTc(input logic v);
        @(posedge clk);
        transfer_count_end <= v;
    endtask : setTc

    // status bytes reach the host only as result bytes of a command sequence
    task automatic fetch(input logic [1:0] sel, output logic [7:0] val);
        @(posedge clk);
        resultRead <= 1'b1;
        resultSel <= sel;
        @(posedge clk);
        resultRead <= 1'b0;
        resultSel <= ~sel;
        @(posedge clk);
        #1;
        val = resultByte;
    endtask : fetch
endmodule : fdc_host_model

/* fdc_result_status.sv */
`timescale 1ns/1ps
// Behaviour
// RL1: set past-final-sector flag on access beyond the track's last sector.
// RL2: also set it when read/write data ends without terminal count.
// RL3: reserved bits of second, third, fourth status bytes read zero.
// RL4: fourth status byte bits 5 and 3 always read one.
// RL5: set CRC fault flag on ID-field or data-field CRC failure.
// RL6: set overrun flag when host or DMA service comes too late.
// RL7: set sector-missing flag for read, read-ID or read-track search failures.
// RL8: set write-protect violation if protect goes high during write or format.
// RL9: set ID-absent flag after two index pulses, or data mark missing.
// RL10: set deleted-mark mismatch when read type meets the opposite mark.
// RL11: set data-field CRC flag on data-field CRC failure only.
// RL12: set cylinder mismatch when ID track differs from internal track.
// RL13: set bad-track flag when mismatched ID track equals ff.
// RL14: set data-mark-absent flag when no data or deleted mark found.
// RL15: fourth byte bits 6 and 4 show write-protect and track-zero levels.
// RL16: fourth byte bit 2 shows head select, bits 1,0 drive selects.
// RL17: sample two mode straps at hardware reset, pick one of three modes.
// RL18: after hardware reset the FIFO is off, byte-at-a-time transfers.
// RL19: only the configure command setting enables the FIFO.
// RL20: FIFO enabled: byte mode in command/result, burst only in execution.
// RL21: host software counting bytes for media timing keeps FIFO disabled.
// RL22: status bytes are not addressable, only returned in a command sequence.
module fdc_result_status
    import fdc_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic system_mode_strap_a,
    input wire logic system_mode_strap_b,
    input wire drive_pins_t drivePins,
    input wire logic index_pulse_input,
    input wire logic transfer_count_end,
    input wire logic cmdStart,
    input wire cmd_kind_t cmdKind,
    input wire logic [7:0] currentTrack,
    input wire logic [7:0] sectorNumber,
    input wire logic sectorAccess,
    input wire logic execDone,
    input wire logic idSearchActive,
    input wire logic idMarkFound,
    input wire media_evt_t mediaEvt,
    input wire logic configWrite,
    input wire logic configFifoEnable,
    input wire logic execPhase,
    input wire logic resultRead,
    input wire logic [1:0] resultSel,
    output logic [7:0] resultByte,
    output sys_mode_t sysMode,
    output logic fifoEnabled,
    output logic burstMode
);
    logic [7:0] resultStatusSecond_q;
    logic [7:0] resultStatusThird_q;
    logic [7:0] resultStatusFourth;
    logic wpSync;
    logic trk0Sync;
    logic indexSync;
    logic indexSeen_q;
    logic [1:0] indexCount_q;
    logic tcSeen_q;
    logic rwCmd;
    logic wrCmd;
    logic wpPrev_q;
    logic strapSample_q;
    logic strapA;
    logic strapB;
    cmd_kind_t cmdKind_q;

    // drive and strap pins come from outside the clock domain
    sync3 syncWp (.clk(clk), .rst_b(rst_b), .async_in(drivePins.writeProtect),
        .sync_out(wpSync));
    sync3 syncTrk0 (.clk(clk), .rst_b(rst_b), .async_in(drivePins.trackZero),
        .sync_out(trk0Sync));
    sync3 syncIndex (.clk(clk), .rst_b(rst_b), .async_in(index_pulse_input),
        .sync_out(indexSync));
    sync3 syncStrapA (.clk(clk), .rst_b(rst_b), .async_in(system_mode_strap_a),
        .sync_out(strapA));
    sync3 syncStrapB (.clk(clk), .rst_b(rst_b), .async_in(system_mode_strap_b),
        .sync_out(strapB));

    // remember the command kind for the whole execution
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmdKind_q <= CMD_OTHER;
        end else if (cmdStart) begin
            cmdKind_q <= cmdKind;
        end
    end

    always_comb begin
        rwCmd = (cmdKind_q == CMD_READ_DATA) || (cmdKind_q == CMD_READ_DELETED)
            || (cmdKind_q == CMD_WRITE_DATA) || (cmdKind_q == CMD_WRITE_DELETED);
        wrCmd = (cmdKind_q == CMD_WRITE_DATA) || (cmdKind_q == CMD_WRITE_DELETED)
            || (cmdKind_q == CMD_FORMAT);
    end

    // terminal count seen during this command; cleared at a new command unless terminal count is high in that cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tcSeen_q <= 1'b0;
        end else if (transfer_count_end) begin
            tcSeen_q <= 1'b1;
        end else if (cmdStart) begin
            tcSeen_q <= 1'b0;
        end
    end

    // index pulses counted while hunting for an ID mark; saturates at two
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            indexSeen_q <= 1'b0;
            indexCount_q <= 2'h0;
        end else begin
            indexSeen_q <= indexSync;
            if (cmdStart || idMarkFound || !idSearchActive) begin
                indexCount_q <= 2'h0;
            end else if (indexSync && !indexSeen_q && indexCount_q != INDEX_LIMIT) begin
                indexCount_q <= indexCount_q + 2'h1;
            end
        end
    end

    // previous protect level, to catch a rising edge during a write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wpPrev_q <= 1'b0;
        end else begin
            wpPrev_q <= wpSync;
        end
    end

    // second status byte: sticky per command, events win over the start clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            resultStatusSecond_q <= STATUS_CLEAR;
        end else begin
            if (cmdStart) begin
                resultStatusSecond_q <= STATUS_CLEAR;
            end
            if (mediaEvt.sectorBeyondFinal || (sectorAccess && sectorNumber == SECTOR_LAST)
                || (execDone && rwCmd && !tcSeen_q && !transfer_count_end)) begin
                resultStatusSecond_q[S2_PAST_FINAL] <= 1'b1; // RL1 RL2
            end
            if (mediaEvt.idCrcFail || mediaEvt.dataCrcFail) begin
                resultStatusSecond_q[S2_CRC_FAULT] <= 1'b1; // RL5
            end
            if (mediaEvt.serviceLate) begin
                resultStatusSecond_q[S2_OVERRUN] <= 1'b1; // RL6
            end
            if (((cmdKind_q == CMD_READ_DATA || cmdKind_q == CMD_READ_DELETED)
                    && mediaEvt.sectorNotFound)
                || (cmdKind_q == CMD_READ_ID && mediaEvt.idReadFail)
                || (cmdKind_q == CMD_READ_TRACK && mediaEvt.sequenceFail)) begin
                resultStatusSecond_q[S2_MISSING] <= 1'b1; // RL7
            end
            if (wrCmd && execPhase && wpSync && !wpPrev_q) begin
                resultStatusSecond_q[S2_WP_VIOL] <= 1'b1; // RL8
            end
            if (indexCount_q == INDEX_LIMIT || mediaEvt.idMarkMissing
                || mediaEvt.dataMarkMissing) begin
                resultStatusSecond_q[S2_ID_ABSENT] <= 1'b1; // RL9
            end
        end
    end

    // third status byte, same clearing discipline
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            resultStatusThird_q <= STATUS_CLEAR;
        end else begin
            if (cmdStart) begin
                resultStatusThird_q <= STATUS_CLEAR;
            end
            if ((cmdKind_q == CMD_READ_DATA && mediaEvt.deletedMarkSeen)
                || (cmdKind_q == CMD_READ_DELETED && mediaEvt.normalMarkSeen)) begin
                resultStatusThird_q[S3_DEL_MISMATCH] <= 1'b1; // RL10
            end
            if (mediaEvt.dataCrcFail) begin
                resultStatusThird_q[S3_DATA_CRC] <= 1'b1; // RL11
            end
            if (mediaEvt.idTrackValid && mediaEvt.idTrack != currentTrack) begin
                resultStatusThird_q[S3_CYL_MISMATCH] <= 1'b1; // RL12
                if (mediaEvt.idTrack == BAD_TRACK_ID) begin
                    resultStatusThird_q[S3_BAD_TRACK] <= 1'b1; // RL13
                end
            end
            if (mediaEvt.dataMarkMissing) begin
                resultStatusThird_q[S3_MARK_ABSENT] <= 1'b1; // RL14
            end
        end
    end

    // fourth byte is live pin state with the fixed ones; reserved bits stay zero
    always_comb begin
        resultStatusFourth = S4_FIXED_ONES; // RL4 RL3
        resultStatusFourth[S4_WP] = wpSync; // RL15
        resultStatusFourth[S4_TRACK_ZERO_INPUT] = trk0Sync; // RL15
        resultStatusFourth[S4_HEAD] = drivePins.headSelect; // RL16
        resultStatusFourth[S4_DS_HI] = drivePins.driveSelectHigh; // RL16
        resultStatusFourth[S4_DS_LO] = drivePins.driveSelectLow; // RL16
    end

    // bytes only leave through the result sequence, there is no address map
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            resultByte <= STATUS_CLEAR;
        end else if (resultRead) begin
            unique case (resultSel) // RL22
                SEL_SECOND: resultByte <= resultStatusSecond_q; // RL3
                SEL_THIRD: resultByte <= resultStatusThird_q; // RL3
                SEL_FOURTH: resultByte <= resultStatusFourth;
                default: resultByte <= STATUS_CLEAR;
            endcase
        end
    end

    // straps sampled once, right after the synchronisers settle past reset
    logic [2:0] strapWait_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strapWait_q <= 3'h0;
            strapSample_q <= 1'b0;
            sysMode <= MODE_AT;
        end else begin
            if (strapWait_q != STRAP_WAIT_END) begin
                strapWait_q <= strapWait_q + 3'h1;
            end
            // three stages plus the agree flop take four edges; sampling earlier reads zero
            if (strapWait_q == STRAP_WAIT_END && !strapSample_q) begin
                strapSample_q <= 1'b1;
                unique case ({strapB, strapA}) // RL17
                    2'h0: sysMode <= MODE_M30;
                    2'h1: sysMode <= MODE_PS2;
                    default: sysMode <= MODE_AT;
                endcase
            end
        end
    end

    // fifo off after reset; only the configure setting turns it on
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fifoEnabled <= 1'b0; // RL18
        end else if (configWrite) begin
            fifoEnabled <= configFifoEnable; // RL19
        end
    end

    // burst only in execution; byte mode keeps status polling compatible
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            burstMode <= 1'b0;
        end else begin
            burstMode <= (configWrite ? configFifoEnable : fifoEnabled) && execPhase; // RL20
        end
    end

    a_past_final_no_tc: assert property (@(posedge clk) disable iff (!rst_b) // RL2
        execDone && rwCmd && !tcSeen_q && !transfer_count_end
        |=> resultStatusSecond_q[S2_PAST_FINAL])
        else $error("past-final flag missing without terminal count");
    a_crc_fault_set: assert property (@(posedge clk) disable iff (!rst_b) // RL5
        mediaEvt.dataCrcFail |=> resultStatusSecond_q[S2_CRC_FAULT]
        && resultStatusThird_q[S3_DATA_CRC])
        else $error("crc flags not set together");
    a_overrun_set: assert property (@(posedge clk) disable iff (!rst_b) // RL6
        mediaEvt.serviceLate |=> resultStatusSecond_q[S2_OVERRUN])
        else $error("overrun flag not set");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b) // RL3
        resultRead && resultSel == SEL_SECOND |=> resultByte[6] == 1'b0
        && resultByte[3] == 1'b0)
        else $error("reserved second-byte bit not zero");
    a_fourth_ones: assert property (@(posedge clk) disable iff (!rst_b) // RL4
        resultRead && resultSel == SEL_FOURTH |=> resultByte[5] && resultByte[3]
        && !resultByte[7])
        else $error("fourth byte fixed bits wrong");
    a_bad_track_pair: assert property (@(posedge clk) disable iff (!rst_b) // RL13
        resultStatusThird_q[S3_BAD_TRACK] |-> resultStatusThird_q[S3_CYL_MISMATCH])
        else $error("bad track without cylinder mismatch");
    a_bad_track_set: assert property (@(posedge clk) disable iff (!rst_b) // RL13
        mediaEvt.idTrackValid && mediaEvt.idTrack == BAD_TRACK_ID
        && mediaEvt.idTrack != currentTrack |=> resultStatusThird_q[S3_BAD_TRACK])
        else $error("bad track id not flagged");
    a_cyl_mismatch_set: assert property (@(posedge clk) disable iff (!rst_b) // RL12
        mediaEvt.idTrackValid && mediaEvt.idTrack != currentTrack
        |=> resultStatusThird_q[S3_CYL_MISMATCH])
        else $error("cylinder mismatch not flagged");
    a_mark_mismatch: assert property (@(posedge clk) disable iff (!rst_b) // RL10
        cmdKind_q == CMD_READ_DATA && mediaEvt.deletedMarkSeen
        |=> resultStatusThird_q[S3_DEL_MISMATCH])
        else $error("deleted-mark mismatch not flagged");
    a_burst_exec_only: assert property (@(posedge clk) disable iff (!rst_b) // RL20
        !$past(execPhase) |-> !burstMode)
        else $error("burst mode outside execution");
    a_fifo_needs_config: assert property (@(posedge clk) disable iff (!rst_b) // RL19
        $rose(fifoEnabled) |-> $past(configWrite && configFifoEnable))
        else $error("fifo enabled without configure");
    a_index_twice: assert property (@(posedge clk) disable iff (!rst_b) // RL9
        indexCount_q == INDEX_LIMIT |=> resultStatusSecond_q[S2_ID_ABSENT])
        else $error("id-absent not set after two index pulses");

    c_burst: cover property (@(posedge clk) disable iff (!rst_b) burstMode);
    c_wp_viol: cover property (@(posedge clk) disable iff (!rst_b)
        resultStatusSecond_q[S2_WP_VIOL]);
    c_bad_track: cover property (@(posedge clk) disable iff (!rst_b)
        resultStatusThird_q[S3_BAD_TRACK]);
    c_id_absent: cover property (@(posedge clk) disable iff (!rst_b)
        indexCount_q == INDEX_LIMIT);
endmodule : fdc_result_status

/* fdc_status_pkg.sv */
package fdc_status_pkg;

    // result status byte 2 (second) bit positions
    localparam int unsigned S2_PAST_FINAL = 7;
    localparam int unsigned S2_CRC_FAULT = 5;
    localparam int unsigned S2_OVERRUN = 4;
    localparam int unsigned S2_MISSING = 2;
    localparam int unsigned S2_WP_VIOL = 1;
    localparam int unsigned S2_ID_ABSENT = 0;
    // third status byte bit positions
    localparam int unsigned S3_DEL_MISMATCH = 6;
    localparam int unsigned S3_DATA_CRC = 5;
    localparam int unsigned S3_CYL_MISMATCH = 4;
    localparam int unsigned S3_BAD_TRACK = 1;
    localparam int unsigned S3_MARK_ABSENT = 0;
    // fourth status byte bit positions
    localparam int unsigned S4_WP = 6;
    localparam int unsigned S4_TRACK_ZERO_INPUT = 4;
    localparam int unsigned S4_HEAD = 2;
    localparam int unsigned S4_DS_HI = 1;
    localparam int unsigned S4_DS_LO = 0;
    // fixed ones of the fourth byte (bits 5 and 3)
    localparam logic [7:0] S4_FIXED_ONES = 8'h28;
    localparam logic [7:0] STATUS_CLEAR = 8'h00;
    localparam logic [7:0] BAD_TRACK_ID = 8'hff;
    localparam logic [7:0] SECTOR_LAST = 8'hff;
    // index pulses that end an unsuccessful ID hunt
    localparam logic [1:0] INDEX_LIMIT = 2'h2;
    // edges after reset until the strap synchronisers have settled
    localparam logic [2:0] STRAP_WAIT_END = 3'h4;

    // result byte selector within the result phase
    localparam logic [1:0] SEL_SECOND = 2'h1;
    localparam logic [1:0] SEL_THIRD = 2'h2;
    localparam logic [1:0] SEL_FOURTH = 2'h3;

    typedef enum logic [1:0] {
        MODE_AT,
        MODE_PS2,
        MODE_M30
    } sys_mode_t;

    typedef enum logic [2:0] {
        CMD_OTHER,
        CMD_READ_DATA,
        CMD_READ_DELETED,
        CMD_WRITE_DATA,
        CMD_WRITE_DELETED,
        CMD_FORMAT,
        CMD_READ_ID,
        CMD_READ_TRACK
    } cmd_kind_t;

    // media events reported by the disk-side sequencer, one-cycle pulses
    typedef struct packed {
        logic sectorBeyondFinal;
        logic idCrcFail;
        logic dataCrcFail;
        logic serviceLate;
        logic sectorNotFound;
        logic idReadFail;
        logic sequenceFail;
        logic idMarkMissing;
        logic dataMarkMissing;
        logic deletedMarkSeen;
        logic normalMarkSeen;
        logic idTrackValid;
        logic [7:0] idTrack;
    } media_evt_t;

    // drive pins seen by the status byte
    typedef struct packed {
        logic writeProtect;
        logic trackZero;
        logic headSelect;
        logic driveSelectHigh;
        logic driveSelectLow;
    } drive_pins_t;

endpackage : fdc_status_pkg

/* sync3.sv */
`timescale 1ns/1ps
// three-stage synchroniser; output changes once stages two and three agree
module sync3 (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic async_in,
    output logic sync_out
);
    logic [2:0] stage_q;

    // stage 0 only feeds stage 1, never any logic
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage_q <= 3'h0;
        end else begin
            stage_q <= {stage_q[1:0], async_in};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_out <= 1'b0;
        end else if (stage_q[1] == stage_q[2]) begin
            sync_out <= stage_q[2];
        end
    end
endmodule : sync3

/* tb.sv */
`timescale 1ns/1ps
// self-checking bench for result status bytes, mode straps and fifo mode
module tb
    import fdc_status_pkg::*;
;
    logic clk, rst_b, system_mode_strap_a, system_mode_strap_b, indexIn, tcEnd;
    logic cmdStart, sectorAccess, execDone, idSearchActive, idMarkFound, execPhase;
    logic configWrite, configFifoEnable, resultRead, fifoEnabled, burstMode, fifoExp;
    logic [1:0] resultSel;
    logic [7:0] currentTrack, sectorNumber, resultByte, got, trk;
    drive_pins_t drivePins;
    cmd_kind_t cmdKind, k;
    media_evt_t mediaEvt, ev;
    sys_mode_t sysMode, expMode;
    int failures = 0;
    int nTests = 0;
    int cycles = 0;
    int seed = 32'hc2c9;

    fdc_result_status u_fdc_result_status (.clk(clk), .rst_b(rst_b),
        .system_mode_strap_a(system_mode_strap_a), .system_mode_strap_b(system_mode_strap_b),
        .drivePins(drivePins), .index_pulse_input(indexIn), .transfer_count_end(tcEnd),
        .cmdStart(cmdStart), .cmdKind(cmdKind), .currentTrack(currentTrack),
        .sectorNumber(sectorNumber), .sectorAccess(sectorAccess), .execDone(execDone),
        .idSearchActive(idSearchActive), .idMarkFound(idMarkFound), .mediaEvt(mediaEvt),
        .configWrite(configWrite), .configFifoEnable(configFifoEnable),
        .execPhase(execPhase), .resultRead(resultRead), .resultSel(resultSel),
        .resultByte(resultByte), .sysMode(sysMode), .fifoEnabled(fifoEnabled),
        .burstMode(burstMode));

    fdc_host_model u_fdc_host_model (.clk(clk), .resultByte(resultByte),
        .configWrite(configWrite), .configFifoEnable(configFifoEnable),
        .resultRead(resultRead), .resultSel(resultSel), .transfer_count_end(tcEnd));

    // 20 MHz clock
    always #25 clk = ~clk;

    // hang guard, well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        nTests++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step

    // expected second and third bytes, reserved bits left at zero
    function automatic logic [15:0] expStatus(input cmd_kind_t kd, input media_evt_t e,
            input logic [7:0] tr, input logic [7:0] sn, input logic tc, input logic wpRise,
            input logic lostId);
        logic [7:0] s2;
        logic [7:0] s3;
        logic wrongCyl;
        logic isWrite;
        wrongCyl = e.idTrackValid && (e.idTrack != tr);
        isWrite = kd == CMD_WRITE_DATA || kd == CMD_WRITE_DELETED || kd == CMD_FORMAT;
        s2 = 8'h00;
        s3 = 8'h00;
        s2[7] = e.sectorBeyondFinal || sn == 8'hff;
        s2[7] = s2[7] || (!tc && (kd == CMD_READ_DATA || kd == CMD_WRITE_DATA));
        s2[5] = e.idCrcFail || e.dataCrcFail;
        s2[4] = e.serviceLate;
        s2[2] = ((kd == CMD_READ_DATA || kd == CMD_READ_DELETED) && e.sectorNotFound)
            || (kd == CMD_READ_ID && e.idReadFail)
            || (kd == CMD_READ_TRACK && e.sequenceFail);
        s2[1] = wpRise && isWrite;
        s2[0] = e.idMarkMissing || e.dataMarkMissing || lostId;
        s3[6] = (e.deletedMarkSeen && kd == CMD_READ_DATA)
            || (e.normalMarkSeen && kd == CMD_READ_DELETED);
        s3[5] = e.dataCrcFail;
        s3[4] = wrongCyl;
        s3[1] = wrongCyl && e.idTrack == 8'hff;
        s3[0] = e.dataMarkMissing;
        return {s2, s3};
    endfunction : expStatus

    function automatic logic [7:0] expFourth(input drive_pins_t d);
        return 8'h28 | {1'b0, d.writeProtect, 1'b0, d.trackZero, 1'b0, d.headSelect,
            d.driveSelectHigh, d.driveSelectLow};
    endfunction : expFourth

    // one full command: start, media events, index pulses, end, three result bytes
    task automatic runCmd(input cmd_kind_t kd, input media_evt_t e, input logic [7:0] tr,
            input logic [7:0] sn, input logic tc, input logic wpRise, input int idx,
            input logic mark);
        logic [15:0] exp;
        logic [7:0] val;
        exp = expStatus(kd, e, tr, sn, tc, wpRise, idx == 2 && !mark);
        if (wpRise) begin
            drivePins.writeProtect <= 1'b0;
            step(6);
        end
        @(posedge clk);
        cmdStart <= 1'b1;
        cmdKind <= kd;
        currentTrack <= tr;
        execPhase <= 1'b1;
        idSearchActive <= 1'b1;
        @(posedge clk);
        cmdStart <= 1'b0;
        cmdKind <= cmd_kind_t'(~kd);
        mediaEvt <= e;
        sectorNumber <= sn;
        sectorAccess <= 1'b1;
        if (wpRise) begin
            drivePins.writeProtect <= 1'b1;
        end
        @(posedge clk);
        mediaEvt <= '0;
        sectorAccess <= 1'b0;
        // a found mark between two index pulses must restart the count
        for (int p = 0; p < idx; p++) begin
            indexIn <= 1'b1;
            step(4);
            indexIn <= 1'b0;
            idMarkFound <= mark && p == 0;
            step(1);
            idMarkFound <= 1'b0;
            step(3);
        end
        step(6);
        u_fdc_host_model.setTc(tc);
        @(posedge clk);
        execDone <= 1'b1;
        @(posedge clk);
        execDone <= 1'b0;
        execPhase <= 1'b0;
        idSearchActive <= 1'b0;
        #1;
        check("burst", {7'h00, burstMode}, {7'h00, fifoExp});
        u_fdc_host_model.setTc(1'b0);
        u_fdc_host_model.fetch(SEL_SECOND, val);
        check("second", val, exp[15:8]);
        u_fdc_host_model.fetch(SEL_THIRD, val);
        check("third", val, exp[7:0]);
        u_fdc_host_model.fetch(SEL_FOURTH, val);
        check("fourth", val, expFourth(drivePins));
    endtask : runCmd

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        {system_mode_strap_a, system_mode_strap_b, indexIn, cmdStart, sectorAccess} = '0;
        {execDone, idSearchActive, idMarkFound, execPhase} = '0;
        currentTrack = 8'h00;
        sectorNumber = 8'h00;
        drivePins = '0;
        mediaEvt = '0;
        cmdKind = CMD_OTHER;
        // three strap settings (both low, a high, b high), each behind its own hardware reset
        for (int m = 0; m < 3; m++) begin
            rst_b <= 1'b0;
            system_mode_strap_b <= m[1];
            system_mode_strap_a <= m[0];
            step(12);
            rst_b <= 1'b1;
            step(6);
            #1;
            expMode = (m == 0) ? MODE_M30 : (m == 1) ? MODE_PS2 : MODE_AT;
            check("mode", {6'h00, sysMode}, {6'h00, expMode});
            check("fifo", {7'h00, fifoEnabled}, 8'h00);
        end
        // fifo off after reset, on only by configure, bursts only in execution
        @(posedge clk);
        execPhase <= 1'b1;
        step(3);
        #1;
        check("burst", {7'h00, burstMode}, 8'h00);
        u_fdc_host_model.configure(1'b1);
        step(2);
        #1;
        check("fifo", {7'h00, fifoEnabled}, 8'h01);
        check("burst", {7'h00, burstMode}, 8'h01);
        @(posedge clk);
        execPhase <= 1'b0;
        step(2);
        #1;
        check("burst", {7'h00, burstMode}, 8'h00);
        fifoExp = 1'b1;
        // random commands with sparse events and boundary tracks and sectors
        for (int i = 0; i < 48; i++) begin
            if (i == 24) begin
                u_fdc_host_model.configure(1'b0);
                fifoExp = 1'b0;
            end
            @(posedge clk);
            drivePins <= drive_pins_t'($random(seed));
            step(8);
            k = cmd_kind_t'($random(seed));
            ev = media_evt_t'($random(seed) & $random(seed));
            trk = 8'($random(seed));
            ev.idTrack = (i % 4 == 0) ? 8'hff : (i % 4 == 1) ? trk : 8'($random(seed));
            runCmd(k, ev, trk, (i % 5 == 0) ? 8'hff : (i % 5 == 1) ? 8'hfe : 8'($random(seed)),
                i % 3 != 0 || k == CMD_READ_DELETED || k == CMD_WRITE_DELETED,
                1'($random(seed)), i % 3, 1'($random(seed)));
        end
        // a new command must not disturb the last result byte, but clears the flags
        @(posedge clk);
        cmdStart <= 1'b1;
        cmdKind <= CMD_OTHER;
        @(posedge clk);
        cmdStart <= 1'b0;
        step(3);
        #1;
        check("held", resultByte, expFourth(drivePins));
        u_fdc_host_model.fetch(SEL_SECOND, got);
        check("cleared", got, 8'h00);
        u_fdc_host_model.fetch(2'h0, got);
        check("unselected", got, 8'h00);
        conclude();
    end
endmodule : tb
